// ==== core/lkc_bus_resp.sv ====
// bus response logic of a look-aside secondary cache
// assumes bus signals are active high, except tbst, ci and wt active low, and on core_clk_i; AHB-Lite slave for control
//
// Our own choices: the address map and the AHB-Lite slave port.
`timescale 1ns/1ps
`include "lkc_regs.svh"
module lkc_bus_resp (
	input  wire logic        core_clk_i,
	input  wire logic        reset_i,
	input  wire logic        hsel_i,
	input  wire logic [31:0] haddr_i,
	input  wire logic [1:0]  htrans_i,
	input  wire logic        hwrite_i,
	input  wire logic [2:0]  hsize_i,
	input  wire logic [31:0] hwdata_i,
	input  wire logic        hready_i,
	output logic      [31:0] hrdata_o,
	output logic             hreadyout_o,
	output logic             hresp_o,
	input  wire logic        ts_i,
	input  wire logic [31:0] addr_i,
	input  wire logic [4:0]  tt_i,
	input  wire logic        tbst_i,
	input  wire logic        ci_i,
	input  wire logic        wt_i,
	input  wire logic        snoop_i,
	input  wire logic        aack_i,
	input  wire logic        artry_i,
	input  wire logic        br_others_i,
	input  wire logic        data_busy_i,
	input  wire logic        ta_i,
	input  wire logic        cache_bus_grant_i,
	input  wire logic        cache_data_bus_grant_i,
	output logic             hit_claim_o,
	output logic             aack_o,
	output logic             artry_o,
	output logic             ta_o,
	output logic             cache_bus_request_o,
	output lkc_pkg::lkc_cb_s cb_o,
	output logic             fill_o,
	output logic             update_o,
	output logic             cob_src_o
);
	// ****************************************
	// declarations
	// ****************************************
	lkc_pkg::lkc_state_e        st_reg;
	lkc_pkg::lkc_state_e        st_next;
	lkc_pkg::lkc_act_e          act_reg;
	lkc_pkg::lkc_act_e          act_next;
	lkc_pkg::lkc_tag_s          rd_tag;
	lkc_pkg::lkc_tag_s          victim_reg;
	lkc_pkg::lkc_tag_s          wd;
	logic                       we;
	logic [`LKC_IDX_W-1:0]      widx;
	logic [31:0]                req_addr_reg;
	logic [4:0]                 tt_reg;
	logic                       tbst_reg;
	logic                       ci_reg;
	logic                       wt_reg;
	logic                       snp_reg;
	logic                       ps_v_reg;
	logic                       ps_hit_reg;
	logic                       ps_wr_reg;
	logic                       cob_valid_reg;
	logic [31:0]                cob_addr_reg;
	logic [31:0]                push_addr_reg;
	logic [2:0]                 beat_reg;
	logic                       enable_reg;
	logic                       hit;
	logic                       dirty;
	logic                       cobm;
	logic                       fill_cancel;
	logic                       claiming;
	logic                       ahb_rd_reg;
	logic                       ahb_wr_reg;
	logic [3:0]                 ahb_addr_reg;
	logic [`LKC_TAG_W-1:0]      req_tag;
	logic [`LKC_IDX_W-1:0]      req_idx;

	// ****************************************
	// helpers
	// ****************************************
	// transfer type match with care mask, set bits compared
	function automatic logic tmatch(input logic [4:0] tt, input logic [4:0] val, input logic [4:0] care);
		tmatch = ((tt ^ val) & care) == 5'h00;
	endfunction

	// response selection from attributes and tag status
	function automatic lkc_pkg::lkc_act_e decide(input logic snp, input logic [4:0] tt, input logic tbst,
		input logic ci, input logic wt, input logic h, input logic d, input logic cm,
		input logic psv, input logic psh, input logic psw);
		decide = lkc_pkg::ACT_NONE; // unlisted rows do nothing [RULE_25]
		if (!snp) begin
			if (tmatch(tt, 5'h0A, 5'h0B) && !tbst && ci) begin
				if (h) decide = lkc_pkg::ACT_CLAIM; // [RULE_02]
				else if (cm) decide = lkc_pkg::ACT_COBRD; // [RULE_12]
				else decide = lkc_pkg::ACT_FILL; // [RULE_01]
			end else if (tmatch(tt, 5'h0A, 5'h0F) && tbst && !ci && h) begin
				decide = d ? lkc_pkg::ACT_PUSH_INV : lkc_pkg::ACT_INVAL; // [RULE_03]
			end else if (tt == 5'h06 && !tbst && ci) begin
				if (psv && psw) decide = h ? lkc_pkg::ACT_INVAL : lkc_pkg::ACT_NONE; // [RULE_15] [RULE_04] [RULE_05]
				else if (psv && psh && h) decide = lkc_pkg::ACT_UPDATE; // [RULE_15]
				else if (!h) decide = lkc_pkg::ACT_FILL; // [RULE_04]
				else if (wt) decide = lkc_pkg::ACT_CLAIM_WR; // [RULE_05]
				else decide = lkc_pkg::ACT_UPDATE; // [RULE_06]
			end else if (tmatch(tt, 5'h02, 5'h1B) && ci && !wt && h) begin
				if (!d) decide = lkc_pkg::ACT_UPDATE; // [RULE_06]
				else if (tt == 5'h02 && tbst) decide = lkc_pkg::ACT_PUSH_CLEAN; // [RULE_07]
			end else if (tmatch(tt, 5'h02, 5'h0F) && tbst && !ci && h) begin
				decide = d ? lkc_pkg::ACT_PUSH_INV : lkc_pkg::ACT_INVAL; // [RULE_03]
			end else if (tt == 5'h04 && h) begin
				decide = d ? lkc_pkg::ACT_PUSH_INV : lkc_pkg::ACT_INVAL; // [RULE_08]
			end else if (tt == 5'h00 && h && d) begin
				decide = lkc_pkg::ACT_PUSH_CLEAN; // [RULE_09]
			end else if (tt == 5'h0C && h) begin
				decide = lkc_pkg::ACT_INVAL; // [RULE_10]
			end
		end else if (h) begin
			if (tt == 5'h04 || tmatch(tt, 5'h02, 5'h0F) || tmatch(tt, 5'h0E, 5'h0F)) begin
				decide = d ? lkc_pkg::ACT_PUSH_INV : lkc_pkg::ACT_INVAL; // [RULE_16]
			end else if ((tt == 5'h00 || tmatch(tt, 5'h0A, 5'h0F)) && d) begin
				decide = lkc_pkg::ACT_PUSH_CLEAN; // [RULE_17]
			end else if (tmatch(tt, 5'h0C, 5'h1E) || tt == 5'h06) begin
				decide = lkc_pkg::ACT_INVAL; // [RULE_16]
			end
		end
	endfunction

	// ****************************************
	// tag lookup
	// ****************************************
	assign req_tag = req_addr_reg[31:`LKC_TAG_LSB];
	assign req_idx = req_addr_reg[`LKC_TAG_LSB-1:`LKC_IDX_LSB];

	lkc_tag_mem u_tags (
		.core_clk_i (core_clk_i),
		.reset_i    (reset_i),
		.rd_en_i    (ts_i && st_reg == lkc_pkg::ST_IDLE),
		.rd_idx_i   (addr_i[`LKC_TAG_LSB-1:`LKC_IDX_LSB]),
		.rd_data_o  (rd_tag),
		.wr_en_i    (we),
		.wr_idx_i   (widx),
		.wr_data_i  (wd)
	);

	// status one cycle after start, cast-out buffer compare
	assign hit         = rd_tag.valid && rd_tag.tag == req_tag; // [RULE_24]
	assign dirty       = hit && rd_tag.dirty; // [RULE_24]
	assign cobm        = cob_valid_reg && cob_addr_reg[31:`LKC_LINE_LSB] == req_addr_reg[31:`LKC_LINE_LSB];
	assign fill_cancel = rd_tag.valid && rd_tag.dirty && cob_valid_reg && !(!tt_reg[3] && cobm); // [RULE_11]
	assign act_next    = enable_reg ? decide(snp_reg, tt_reg, tbst_reg, ci_reg, wt_reg, hit, dirty, cobm,
	                                         ps_v_reg, ps_hit_reg, ps_wr_reg) : lkc_pkg::ACT_NONE;
	assign claiming    = act_reg == lkc_pkg::ACT_CLAIM || act_reg == lkc_pkg::ACT_CLAIM_WR ||
	                     act_reg == lkc_pkg::ACT_COBRD;

	// ****************************************
	// sequencer
	// ****************************************
	// next state
	always_comb begin
		st_next = st_reg;
		case (st_reg)
			lkc_pkg::ST_IDLE: begin
				if (ts_i) st_next = lkc_pkg::ST_LOOK;
				else if (cob_valid_reg && enable_reg && !data_busy_i) st_next = lkc_pkg::ST_REQ;
			end
			lkc_pkg::ST_LOOK: begin
				case (act_next)
					lkc_pkg::ACT_CLAIM, lkc_pkg::ACT_CLAIM_WR, lkc_pkg::ACT_COBRD: st_next = lkc_pkg::ST_CLAIM;
					lkc_pkg::ACT_FILL: st_next = fill_cancel ? lkc_pkg::ST_IDLE : lkc_pkg::ST_CLAIM;
					lkc_pkg::ACT_PUSH_INV, lkc_pkg::ACT_PUSH_CLEAN: st_next = lkc_pkg::ST_RETRY;
					default: st_next = lkc_pkg::ST_IDLE;
				endcase
			end
			lkc_pkg::ST_CLAIM: begin
				if (!claiming && artry_i) st_next = lkc_pkg::ST_IDLE; // [RULE_13]
				else if (claiming ? !data_busy_i : aack_i) st_next = lkc_pkg::ST_WIN; // [RULE_21]
			end
			lkc_pkg::ST_WIN: begin
				if (artry_i || !claiming) st_next = lkc_pkg::ST_IDLE; // [RULE_14]
				else st_next = lkc_pkg::ST_DATA;
			end
			lkc_pkg::ST_DATA: begin
				if (beat_reg == 3'h1) st_next = lkc_pkg::ST_IDLE;
			end
			lkc_pkg::ST_RETRY: begin
				if (aack_i) st_next = lkc_pkg::ST_RWIN; // [RULE_23]
			end
			lkc_pkg::ST_RWIN: st_next = lkc_pkg::ST_BRWIN; // [RULE_23]
			lkc_pkg::ST_BRWIN: begin
				st_next = br_others_i ? lkc_pkg::ST_IDLE : lkc_pkg::ST_REQ; // [RULE_18]
			end
			lkc_pkg::ST_REQ: begin
				if (cache_bus_grant_i) st_next = lkc_pkg::ST_PADDR;
			end
			lkc_pkg::ST_PADDR: st_next = lkc_pkg::ST_PDATA;
			lkc_pkg::ST_PDATA: begin
				if (artry_i) st_next = lkc_pkg::ST_REQ;
				else if (ta_i && cache_data_bus_grant_i && beat_reg == 3'h1) st_next = lkc_pkg::ST_IDLE;
			end
			default: st_next = lkc_pkg::ST_IDLE;
		endcase
	end

	// state register
	always_ff @(posedge core_clk_i or posedge reset_i) begin
		if (reset_i) st_reg <= lkc_pkg::ST_IDLE;
		else st_reg <= st_next;
	end

	// transfer capture and chosen action
	always_ff @(posedge core_clk_i or posedge reset_i) begin
		if (reset_i) begin
			req_addr_reg <= '0;
			tt_reg       <= '0;
			tbst_reg     <= 1'h0;
			ci_reg       <= 1'h0;
			wt_reg       <= 1'h0;
			snp_reg      <= 1'h0;
			act_reg      <= lkc_pkg::ACT_NONE;
		end else if (st_reg == lkc_pkg::ST_IDLE) begin
			req_addr_reg <= addr_i;
			tt_reg       <= tt_i;
			tbst_reg     <= tbst_i;
			ci_reg       <= ci_i;
			wt_reg       <= wt_i;
			snp_reg      <= snoop_i;
			act_reg      <= ts_i ? lkc_pkg::ACT_NONE : lkc_pkg::ACT_DRAIN;
		end else if (st_reg == lkc_pkg::ST_LOOK) begin
			act_reg <= act_next;
		end
	end

	// snoop history for the following processor burst write
	always_ff @(posedge core_clk_i or posedge reset_i) begin
		if (reset_i) begin
			ps_v_reg   <= 1'h0;
			ps_hit_reg <= 1'h0;
			ps_wr_reg  <= 1'h0;
		end else if (st_reg == lkc_pkg::ST_LOOK) begin
			ps_v_reg   <= snp_reg; // [RULE_15]
			ps_hit_reg <= hit;
			ps_wr_reg  <= !tt_reg[3];
		end
	end

	// victim save, cast-out buffer and push address
	always_ff @(posedge core_clk_i or posedge reset_i) begin
		if (reset_i) begin
			victim_reg    <= '0;
			cob_valid_reg <= 1'h0;
			cob_addr_reg  <= '0;
			push_addr_reg <= '0;
		end else begin
			if (st_reg == lkc_pkg::ST_LOOK) begin
				victim_reg    <= rd_tag;
				push_addr_reg <= {req_addr_reg[31:`LKC_LINE_LSB], 5'h00};
				if (act_next == lkc_pkg::ACT_FILL && !fill_cancel && rd_tag.valid && rd_tag.dirty) begin
					cob_valid_reg <= 1'h1;
					cob_addr_reg  <= {rd_tag.tag, req_idx, 5'h00};
				end
			end
			if (st_reg == lkc_pkg::ST_IDLE && st_next == lkc_pkg::ST_REQ) push_addr_reg <= cob_addr_reg;
			if (act_reg == lkc_pkg::ACT_FILL && artry_i &&
			    (st_reg == lkc_pkg::ST_CLAIM || st_reg == lkc_pkg::ST_WIN)) cob_valid_reg <= 1'h0; // [RULE_13]
			if (act_reg == lkc_pkg::ACT_DRAIN && st_reg == lkc_pkg::ST_PDATA && st_next == lkc_pkg::ST_IDLE)
				cob_valid_reg <= 1'h0;
		end
	end

	// beat counter for claimed data and copyback data
	always_ff @(posedge core_clk_i or posedge reset_i) begin
		if (reset_i) beat_reg <= 3'h0;
		else if (st_reg == lkc_pkg::ST_WIN) beat_reg <= tbst_reg ? `LKC_BEATS_ONE : `LKC_BEATS_BURST;
		else if (st_reg == lkc_pkg::ST_PADDR) beat_reg <= `LKC_BEATS_BURST;
		else if (st_reg == lkc_pkg::ST_DATA) beat_reg <= beat_reg - 3'h1;
		else if (st_reg == lkc_pkg::ST_PDATA && ta_i && cache_data_bus_grant_i) beat_reg <= beat_reg - 3'h1;
	end

	// ****************************************
	// tag updates
	// ****************************************
	always_comb begin
		we   = 1'h0;
		widx = req_idx;
		wd   = rd_tag;
		if (st_reg == lkc_pkg::ST_LOOK) begin
			case (act_next)
				lkc_pkg::ACT_INVAL: begin
					we       = 1'h1; // [RULE_10] [RULE_16]
					wd.valid = 1'h0;
				end
				lkc_pkg::ACT_UPDATE: begin
					we       = 1'h1; // [RULE_06] [RULE_15]
					wd.dirty = 1'h0;
				end
				lkc_pkg::ACT_FILL: begin
					we = !fill_cancel; // [RULE_01] [RULE_04] [RULE_11]
					wd = '{valid: 1'h1, dirty: !tt_reg[3], tag: req_tag};
				end
				default: we = 1'h0;
			endcase
		end else if (act_reg == lkc_pkg::ACT_FILL && artry_i &&
		             (st_reg == lkc_pkg::ST_CLAIM || st_reg == lkc_pkg::ST_WIN)) begin
			we = 1'h1; // victim tag back [RULE_13]
			wd = victim_reg;
		end else if (st_reg == lkc_pkg::ST_DATA && st_next == lkc_pkg::ST_IDLE &&
		             act_reg == lkc_pkg::ACT_CLAIM_WR) begin
			we = 1'h1; // copy-back write hit leaves line dirty [RULE_05]
			wd = '{valid: 1'h1, dirty: 1'h1, tag: req_tag};
		end else if (st_reg == lkc_pkg::ST_PDATA && st_next == lkc_pkg::ST_IDLE &&
		             act_reg != lkc_pkg::ACT_DRAIN) begin
			we = 1'h1; // after push: invalidate or clean [RULE_03] [RULE_07] [RULE_08] [RULE_09] [RULE_17]
			wd = '{valid: act_reg == lkc_pkg::ACT_PUSH_CLEAN, dirty: 1'h0, tag: victim_reg.tag};
		end
	end

	// ****************************************
	// bus outputs
	// ****************************************
	assign hit_claim_o = (st_reg == lkc_pkg::ST_LOOK && (act_next == lkc_pkg::ACT_CLAIM ||
	                     act_next == lkc_pkg::ACT_CLAIM_WR || act_next == lkc_pkg::ACT_COBRD)) ||
	                     (claiming && (st_reg == lkc_pkg::ST_CLAIM || st_reg == lkc_pkg::ST_WIN ||
	                     st_reg == lkc_pkg::ST_DATA)); // [RULE_02] [RULE_05]
	assign aack_o      = st_reg == lkc_pkg::ST_CLAIM && claiming && !data_busy_i; // [RULE_21]
	assign ta_o        = st_reg == lkc_pkg::ST_DATA; // [RULE_02]
	assign cob_src_o   = st_reg == lkc_pkg::ST_DATA && act_reg == lkc_pkg::ACT_COBRD; // [RULE_12]
	assign artry_o     = st_reg == lkc_pkg::ST_RETRY || st_reg == lkc_pkg::ST_RWIN; // [RULE_23]
	assign cache_bus_request_o = artry_o || st_reg == lkc_pkg::ST_REQ ||
	                     (st_reg == lkc_pkg::ST_BRWIN && !br_others_i); // [RULE_18]
	assign update_o    = st_reg == lkc_pkg::ST_LOOK && act_next == lkc_pkg::ACT_UPDATE;
	assign fill_o      = st_reg == lkc_pkg::ST_WIN && act_reg == lkc_pkg::ACT_FILL && !artry_i;

	// copyback master attributes
	always_comb begin
		cb_o      = '0;
		cb_o.ts   = st_reg == lkc_pkg::ST_PADDR;
		if (st_reg == lkc_pkg::ST_PADDR || st_reg == lkc_pkg::ST_PDATA) begin
			cb_o.tt   = `LKC_TT_CB; // [RULE_19]
			cb_o.tbst = 1'h0;
			cb_o.ci   = 1'h1;
			cb_o.wt   = 1'h1;
			cb_o.addr = push_addr_reg;
		end
	end

	// ****************************************
	// AHB-Lite control slave
	// ****************************************
	// address phase capture, zero wait states
	always_ff @(posedge core_clk_i or posedge reset_i) begin
		if (reset_i) begin
			ahb_rd_reg   <= 1'h0;
			ahb_wr_reg   <= 1'h0;
			ahb_addr_reg <= 4'h0;
		end else if (hready_i) begin
			ahb_rd_reg   <= hsel_i && htrans_i[1] && !hwrite_i && hsize_i == 3'h2;
			ahb_wr_reg   <= hsel_i && htrans_i[1] && hwrite_i && hsize_i == 3'h2;
			ahb_addr_reg <= haddr_i[3:0];
		end
	end

	// enable bit, written in data phase
	always_ff @(posedge core_clk_i or posedge reset_i) begin
		if (reset_i) enable_reg <= `LKC_CTRL_RST;
		else if (ahb_wr_reg && ahb_addr_reg == `LKC_REG_CTRL) enable_reg <= hwdata_i[0];
	end

	// read data, unmapped reads as zero
	always_comb begin
		case (ahb_addr_reg)
			`LKC_REG_CTRL: hrdata_o = {31'h0, enable_reg};
			`LKC_REG_STAT: hrdata_o = {23'h0, cob_valid_reg, act_reg, st_reg};
			default:       hrdata_o = 32'h0;
		endcase
		if (!ahb_rd_reg) hrdata_o = 32'h0;
	end
	assign hreadyout_o = 1'h1;
	assign hresp_o     = 1'h0;

	// ****************************************
	// checks
	// ****************************************
	default clocking cb_chk @(posedge core_clk_i); endclocking
	default disable iff (reset_i);

	property p_aack_claim;
		aack_o |-> hit_claim_o && !data_busy_i;
	endproperty
	a_aack_claim: assert property (p_aack_claim) else $error("ack without claim or on busy bus"); // [RULE_21]

	property p_burst_beats;
		(st_reg == lkc_pkg::ST_WIN && claiming && !artry_i && !tbst_reg) |=> ta_o [*4] ##1 !ta_o;
	endproperty
	a_burst_beats: assert property (p_burst_beats) else $error("claimed burst not four beats"); // [RULE_02]

	property p_read_abort;
		(st_reg == lkc_pkg::ST_WIN && claiming && artry_i) |=> !ta_o && st_reg == lkc_pkg::ST_IDLE;
	endproperty
	a_read_abort: assert property (p_read_abort) else $error("retried hit not aborted"); // [RULE_14]

	property p_retry_hold;
		(st_reg == lkc_pkg::ST_RETRY && aack_i) |=> artry_o && cache_bus_request_o ##1 !artry_o;
	endproperty
	a_retry_hold: assert property (p_retry_hold) else $error("retry not held through window"); // [RULE_23]

	property p_br_drop;
		(st_reg == lkc_pkg::ST_BRWIN && br_others_i) |-> !cache_bus_request_o ##1 !cache_bus_request_o;
	endproperty
	a_br_drop: assert property (p_br_drop) else $error("request kept after other request"); // [RULE_18]

	property p_cb_attr;
		cb_o.ts |-> cb_o.tt == `LKC_TT_CB && !cb_o.tbst && cb_o.ci && cb_o.wt;
	endproperty
	a_cb_attr: assert property (p_cb_attr) else $error("bad copyback attributes"); // [RULE_19]

	property p_fill_restore;
		(st_reg == lkc_pkg::ST_WIN && act_reg == lkc_pkg::ACT_FILL && artry_i) |-> we && wd == victim_reg
			##1 !cob_valid_reg;
	endproperty
	a_fill_restore: assert property (p_fill_restore) else $error("victim not restored"); // [RULE_13]

	property p_no_action;
		(st_reg == lkc_pkg::ST_LOOK && act_next == lkc_pkg::ACT_NONE) |-> !we ##1 st_reg == lkc_pkg::ST_IDLE;
	endproperty
	a_no_action: assert property (p_no_action) else $error("unlisted transfer acted"); // [RULE_25]

	property p_kill_nopush;
		(st_reg == lkc_pkg::ST_LOOK && !snp_reg && tt_reg == 5'h0C && hit && enable_reg) |-> we && !wd.valid
			##1 !artry_o;
	endproperty
	a_kill_nopush: assert property (p_kill_nopush) else $error("kill block pushed or kept line"); // [RULE_10]
endmodule

// ==== shared/lkc_regs.svh ====
// constants for the look-aside cache bus response block
// assumes one bus clock shared with the register bus
// Notes on behaviour
// RULE_01: processor cacheable burst read miss causes a line fill.
// RULE_02: processor cacheable burst read hit: claim, end address tenure, supply data beats.
// RULE_03: non-cacheable single-beat hit invalidates; dirty line is retried and pushed first.
// RULE_04: processor burst write miss fills, except right after a snoop hit; the code skips the fill after any snoop write and fills after a snoop read.
// RULE_05: copy-back burst write hit is claimed, except right after a snoop hit; the code invalidates instead of claiming after any snoop write.
// RULE_06: write-through write hit updates data; burst dirty hit also clears dirty.
// RULE_07: single-beat write-through dirty hit: retry, push data, keep valid, clear dirty.
// RULE_08: flush block hit invalidates; dirty line is retried and pushed first.
// RULE_09: clean block: clean hit nothing; dirty hit retried, pushed, dirty cleared.
// RULE_10: kill block hit invalidates without any write-back.
// RULE_11: fill over dirty victim is cancelled while cast-out buffer full, unless write hits it.
// RULE_12: burst read missing tags but matching cast-out buffer is served from it, no fill.
// RULE_13: retry during dirty-victim fill restores victim tag and empties cast-out buffer.
// RULE_14: retry during a served read hit aborts the read.
// RULE_15: burst write after snoop: write hit invalidates, write miss no allocate, read hit updates.
// RULE_16: snoop invalidating types invalidate on hit; dirty ones retried and pushed first.
// RULE_17: snoop clean/read types: dirty hit retried, pushed, dirty cleared.
// RULE_18: after retry window, other request seen drops own request and ignores grant.
// RULE_19: copyback write carries type 00010, burst 0, inhibit 1, write-through 1.
// RULE_20: memory controller watches the claim and leaves claimed requests to the cache.
// RULE_21: one pipeline level; claimed transfers hold acknowledge while data bus busy.
// RULE_22: arbiter honours cache request and grants address and data bus.
// RULE_23: retry is held through the cycle after acknowledge, the retry window.
// RULE_24: tag status comes from looked-up valid and dirty one cycle after start.
// RULE_25: unlisted attribute combinations change no tags and cause no bus action.
`ifndef LKC_REGS_SVH
`define LKC_REGS_SVH
`define LKC_IDX_W       6
`define LKC_TAG_W       21
`define LKC_DEPTH       64
`define LKC_IDX_LSB     5
`define LKC_TAG_LSB     11
`define LKC_LINE_LSB    5
`define LKC_BEATS_BURST 3'h4
`define LKC_BEATS_ONE   3'h1
`define LKC_TT_CB       5'h02
`define LKC_REG_CTRL    4'h0
`define LKC_REG_STAT    4'h4
`define LKC_CTRL_RST    1'h1
`endif

// ==== shared/lkc_pkg.sv ====
// types for the look-aside cache bus response block
// assumes lkc_regs.svh on the include path
`include "lkc_regs.svh"
package lkc_pkg;
	typedef struct packed {
		logic                  valid;
		logic                  dirty;
		logic [`LKC_TAG_W-1:0] tag;
	} lkc_tag_s;
	typedef struct packed {
		logic        ts;
		logic [4:0]  tt;
		logic        tbst;
		logic        ci;
		logic        wt;
		logic [31:0] addr;
	} lkc_cb_s;
	typedef enum logic [3:0] {
		ST_IDLE  = 4'h0, ST_LOOK  = 4'h1, ST_CLAIM = 4'h3, ST_WIN  = 4'h2,
		ST_DATA  = 4'h6, ST_RETRY = 4'h7, ST_RWIN  = 4'h5, ST_BRWIN = 4'h4,
		ST_REQ   = 4'hC, ST_PADDR = 4'hD, ST_PDATA = 4'hF
	} lkc_state_e;
	typedef enum logic [3:0] {
		ACT_NONE, ACT_FILL, ACT_COBRD, ACT_CLAIM, ACT_CLAIM_WR, ACT_INVAL,
		ACT_UPDATE, ACT_PUSH_INV, ACT_PUSH_CLEAN, ACT_DRAIN
	} lkc_act_e;
endpackage

// ==== core/lkc_tag_mem.sv ====
// tag memory: valid, dirty and tag per set, registered read
// assumes one write and one read per cycle on the bus clock
`timescale 1ns/1ps
`include "lkc_regs.svh"
module lkc_tag_mem (
	input  wire logic                   core_clk_i,
	input  wire logic                   reset_i,
	input  wire logic                   rd_en_i,
	input  wire logic [`LKC_IDX_W-1:0]  rd_idx_i,
	output lkc_pkg::lkc_tag_s           rd_data_o,
	input  wire logic                   wr_en_i,
	input  wire logic [`LKC_IDX_W-1:0]  wr_idx_i,
	input  lkc_pkg::lkc_tag_s           wr_data_i
);
	// ****************************************
	// storage
	// ****************************************
	lkc_pkg::lkc_tag_s mem_reg [0:`LKC_DEPTH-1];

	// write port, all sets invalid after reset
	always_ff @(posedge core_clk_i or posedge reset_i) begin
		if (reset_i) begin
			for (int i = 0; i < `LKC_DEPTH; i++) begin
				mem_reg[i] <= '0;
			end
		end else if (wr_en_i) begin
			mem_reg[wr_idx_i] <= wr_data_i;
		end
	end

	// registered read port
	always_ff @(posedge core_clk_i or posedge reset_i) begin
		if (reset_i) begin
			rd_data_o <= '0;
		end else if (rd_en_i) begin
			rd_data_o <= mem_reg[rd_idx_i];
		end
	end
endmodule

// ==== sim/lkc_far_model.sv ====
// far side: memory controller and arbiter
// assumes ts and claim sampled on core_clk_i
`timescale 1ns/1ps
module lkc_far_model (
	input  wire logic core_clk_i,
	input  wire logic reset_i,
	input  wire logic ts_i,
	input  wire logic claim_i,
	input  wire logic req_i,
	input  wire logic cb_ts_i,
	output logic      aack_o,
	output logic      ta_o,
	output logic      grant_o
);
	logic       look;
	logic [4:0] beat;
	// ack unclaimed tenures, grant requests, count data beats
	always_ff @(posedge core_clk_i or posedge reset_i) begin
		if (reset_i) begin
			look    <= 1'h0;
			aack_o  <= 1'h0;
			grant_o <= 1'h0;
			beat    <= 5'h00;
		end else begin
			look    <= ts_i;
			aack_o  <= look & ~claim_i;
			grant_o <= req_i | cb_ts_i | (|beat[3:0]); // grant held through own data beats
			beat    <= {beat[3:0], cb_ts_i};
		end
	end
	assign ta_o = |beat[4:1];
endmodule

// ==== sim/lkc_bus_resp_tb_top.sv ====
// testbench: read, kill, push and register scenarios
// assumes lkc_pkg compiled first
`timescale 1ns/1ps
module lkc_bus_resp_tb_top;
	logic [31:0] haddr_i, hwdata_i, addr_i, hrdata_o, nf, nta, nr, ncb, cc, ca, cbt, nu, n_checks, num_errors;
	logic [4:0]  tt_i;
	logic [2:0]  hsize_i;
	logic [1:0]  htrans_i;
	logic        core_clk_i, reset_i, hsel_i, hwrite_i, ts_i, tbst_i, ci_i, wt_i, snoop_i, artry_i, br_others_i;
	logic        data_busy_i, hreadyout_o, hresp_o, hit_claim_o, aack_o, artry_o, ta_o, cache_bus_request_o;
	logic        fill_o, update_o, cob_src_o, aack_i, ta_i, cache_bus_grant_i, cache_data_bus_grant_i;
	wire logic   hready_i = hreadyout_o;
	lkc_pkg::lkc_cb_s cb_o;
	lkc_bus_resp dut (.*);
	lkc_far_model far (.core_clk_i, .reset_i, .ts_i, .claim_i(hit_claim_o), .req_i(cache_bus_request_o),
		.cb_ts_i(cb_o.ts), .aack_o(aack_i), .ta_o(ta_i), .grant_o(cache_bus_grant_i));
	assign cache_data_bus_grant_i = cache_bus_grant_i;
	always #10 core_clk_i = ~core_clk_i;
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("BAD %0t got %0h want %0h", $time, got, exp);
		end
	endtask
	// one tenure from ts, then 30 cycles of observation
	task automatic run(input logic [4:0] tt, input logic b, input logic c, input logic w, input logic [31:0] a);
		@(posedge core_clk_i);
		ts_i <= 1'h1;
		tt_i <= tt;
		{tbst_i, ci_i, wt_i} <= {b, c, w};
		addr_i <= a;
		@(posedge core_clk_i);
		ts_i <= 1'h0;
		{nf, nta, nr, ncb, cc, ca, cbt, nu} = '0;
		for (int i = 1; i < 31; i++) begin
			@(negedge core_clk_i);
			cc = (cc == 0 && hit_claim_o === 1'h1) ? i : cc;
			ca = (ca == 0 && aack_o === 1'h1) ? i : ca;
			nf += (fill_o === 1'h1);
			nu += (update_o === 1'h1);
			nta += (ta_o === 1'h1);
			nr += (artry_o === 1'h1);
			ncb += (cb_o.ts === 1'h1);
			if (cb_o.ts === 1'h1) cbt = {cb_o.tt, cb_o.tbst, cb_o.ci, cb_o.wt};
		end
	endtask
	task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d, input logic [31:0] exp);
		int k;
		@(posedge core_clk_i);
		{hsel_i, htrans_i, haddr_i, hwrite_i} <= {1'h1, 2'h2, a, w};
		k = 0;
		do begin @(posedge core_clk_i); k++; end while (hready_i !== 1'h1 && k < 9);
		{hsel_i, htrans_i, hwdata_i} <= {1'h0, 2'h0, d};
		do begin @(posedge core_clk_i); k++; end while (hready_i !== 1'h1 && k < 18);
		if (!w) chk(hrdata_o, exp);
		if (k > 8) begin num_errors++; give_verdict; end
	endtask
	task automatic t_read;
		run(5'h0A, 1'h0, 1'h1, 1'h1, 32'h0000_0040);
		chk(nf, 32'h1);
		run(5'h0A, 1'h0, 1'h1, 1'h1, 32'h0000_0040);
		chk(cc, 32'h1);
		chk(ca, 32'h2);
		chk(nta, 32'h4);
	endtask
	task automatic t_kill;
		run(5'h0C, 1'h0, 1'h1, 1'h1, 32'h0000_0040);
		chk(nr, 32'h0);
		run(5'h0A, 1'h0, 1'h1, 1'h1, 32'h0000_0040);
		chk(nf, 32'h1);
	endtask
	task automatic t_push;
		run(5'h06, 1'h0, 1'h1, 1'h1, 32'h0001_0080);
		chk(nf, 32'h1);
		run(5'h00, 1'h0, 1'h1, 1'h1, 32'h0001_0080);
		chk(ncb, 32'h1);
		chk(cbt, 32'h13);
		run(5'h00, 1'h0, 1'h1, 1'h1, 32'h0001_0080);
		chk(nr, 32'h0);
	endtask
	task automatic t_reg;
		ahb(1'h0, 32'h0, 32'h0, 32'h1);
		ahb(1'h0, 32'h8, 32'h0, 32'h0);
		ahb(1'h1, 32'h0, 32'h0, 32'h0);
		ahb(1'h0, 32'h0, 32'h0, 32'h0);
		run(5'h0A, 1'h0, 1'h1, 1'h1, 32'h0000_0040);
		chk(cc, 32'h0);
		ahb(1'h1, 32'h0, 32'h1, 32'h0);
	endtask
	// update, copy-back write hit, abandoned push, snoop kill
	task automatic t_br;
		run(5'h02, 1'h1, 1'h1, 1'h0, 32'h0001_0080);
		chk(nu, 32'h1);
		run(5'h06, 1'h0, 1'h1, 1'h1, 32'h0001_0080);
		chk(nta, 32'h4);
		@(posedge core_clk_i) br_others_i <= 1'h1;
		run(5'h00, 1'h0, 1'h1, 1'h1, 32'h0001_0080);
		chk(nr, 32'h2);
		chk(ncb, 32'h0);
		@(posedge core_clk_i) br_others_i <= 1'h0;
		snoop_i <= 1'h1;
		run(5'h0C, 1'h0, 1'h1, 1'h1, 32'h0001_0080);
		@(posedge core_clk_i) snoop_i <= 1'h0;
		run(5'h0A, 1'h0, 1'h1, 1'h1, 32'h0001_0080);
		chk(nf, 32'h1);
	endtask
	task automatic give_verdict;
		$display("checks %0d errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	// reset for five cycles, then the scenarios
	initial begin
		{core_clk_i, reset_i, hsel_i, hwrite_i, ts_i, tbst_i, ci_i, wt_i, snoop_i} = 9'h082;
		{artry_i, br_others_i, data_busy_i, htrans_i, hsize_i} = {5'h00, 3'h2};
		{haddr_i, hwdata_i, addr_i, tt_i, n_checks, num_errors} = '0;
		repeat (5) @(posedge core_clk_i);
		reset_i <= 1'h0;
		t_read;
		t_kill;
		t_push;
		t_reg;
		t_br;
		give_verdict;
	end
endmodule
